// File: core/clk_pin_ctrl.sv
/*
 * Clock pin control: clock output divider and pin mux, external
 * oscillator input select, crystal / external path exclusion, and the
 * Wishbone register slave that steers them.
 * Assumes one 100 MHz system clock, a synchronous active-high reset and
 * asynchronous pin inputs.
 */
// Our own choices: the address map and the Wishbone slave port.
// Functional notes
// - clock output runs at system clock, half or quarter per div select
// - after reset the clock output runs at one quarter rate
// - divider select value three stops the clock output
// - clock reaches shared pin only when its mux selects clock out
// - source bit picks oscillator input pin; tck pin after reset
// - bit 14 set disables the crystal oscillator
// - bit 13 set makes the device ignore the external input path
`timescale 1ns/1ns
module clk_pin_ctrl
    import clk_pin_pkg::*;
(
    input  wire logic                 ref_clk_in,
    input  wire logic                 srst_in,
    input  wire logic                 ce_in,
    // wishbone classic slave
    input  wire logic                 wb_cyc_in,
    input  wire logic                 wb_stb_in,
    input  wire logic                 wb_we_in,
    input  wire logic [WB_ADDR_W-1:0] wb_adr_in,
    input  wire logic [3:0]           wb_sel_in,
    input  wire logic [WB_DATA_W-1:0] wb_dat_in,
    output logic      [WB_DATA_W-1:0] wb_dat_out,
    output logic                      wb_ack_out,
    // clkout shared pin and its other function
    input  wire logic                 gpio_out_in,
    input  wire logic                 gpio_oe_n_in,
    output logic                      clkout_pin_out,
    output logic                      clkout_pin_oe_n_out,
    // oscillator input pins
    input  wire logic                 tck_shared_pin_in,
    input  wire logic                 alt_osc_in_pin_in,
    output logic                      ext_osc_input_out,
    output logic                      ext_osc_path_en_out,
    output logic                      xtal_osc_en_out
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic addr_is(input logic [WB_ADDR_W-1:0] adr,
                                     input logic [7:0]           ofs);
        addr_is = (adr == ofs);
    endfunction

    function automatic logic byte_wr(input logic [3:0] sel,
                                     input int         bit_pos);
        byte_wr = sel[bit_pos / 8];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic [1:0]           div_sel_r;
    logic [1:0]           div_sel_nxt;
    logic                 src_sel_r;
    logic                 src_sel_nxt;
    logic                 ext_off_r;
    logic                 ext_off_nxt;
    logic                 xtal_off_r;
    logic                 xtal_off_nxt;
    logic                 mux_clkout_r;
    logic                 mux_clkout_nxt;
    logic                 ack_r;
    logic                 ack_nxt;
    logic [WB_DATA_W-1:0] rdat_r;
    logic [WB_DATA_W-1:0] rdat_nxt;
    logic                 req;
    logic                 wr;
    logic                 clk_div;

    ////////////////////////////////////////////////////////////////////////
    // pin input synchronisers

    logic [1:0] pin_raw;
    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [1:0] sync3_r;
    logic [1:0] pin_flt_r;
    logic [1:0] pin_flt_nxt;

    assign pin_raw = {alt_osc_in_pin_in, tck_shared_pin_in};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_comb begin
                pin_flt_nxt[gi] = pin_flt_r[gi];
                if (sync2_r[gi] == sync3_r[gi]) begin
                    pin_flt_nxt[gi] = sync3_r[gi];
                end
            end

            always_ff @(posedge ref_clk_in) begin
                if (srst_in) begin
                    sync1_r[gi]   <= 1'b0;
                    sync2_r[gi]   <= 1'b0;
                    sync3_r[gi]   <= 1'b0;
                    pin_flt_r[gi] <= 1'b0;
                end else if (ce_in) begin
                    sync1_r[gi]   <= pin_raw[gi];
                    sync2_r[gi]   <= sync1_r[gi];
                    sync3_r[gi]   <= sync2_r[gi];
                    pin_flt_r[gi] <= pin_flt_nxt[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave and register writes

    assign req = wb_cyc_in && wb_stb_in && !ack_r;
    assign wr  = req && wb_we_in;

    always_comb begin
        div_sel_nxt    = div_sel_r;
        src_sel_nxt    = src_sel_r;
        ext_off_nxt    = ext_off_r;
        xtal_off_nxt   = xtal_off_r;
        mux_clkout_nxt = mux_clkout_r;
        ack_nxt        = req;
        rdat_nxt       = rdat_r;

        if (wr && addr_is(wb_adr_in, EXT_CLK_CTRL_OFS)) begin
            if (byte_wr(wb_sel_in, DIV_SEL_LSB)) begin
                div_sel_nxt = wb_dat_in[DIV_SEL_LSB +: 2];
            end
            if (byte_wr(wb_sel_in, SRC_SEL_BIT)) begin
                src_sel_nxt = wb_dat_in[SRC_SEL_BIT];
            end
        end
        if (wr && addr_is(wb_adr_in, CLK_CTRL_OFS)) begin
            if (byte_wr(wb_sel_in, EXT_PATH_OFF_BIT)) begin
                ext_off_nxt = wb_dat_in[EXT_PATH_OFF_BIT];
            end
            if (byte_wr(wb_sel_in, XTAL_OFF_BIT)) begin
                xtal_off_nxt = wb_dat_in[XTAL_OFF_BIT];
            end
        end
        if (wr && addr_is(wb_adr_in, PIN_MUX_OFS)) begin
            if (byte_wr(wb_sel_in, MUX_CLKOUT_BIT)) begin
                mux_clkout_nxt = wb_dat_in[MUX_CLKOUT_BIT];
            end
        end

        if (req) begin
            rdat_nxt = '0;
            if (!wb_we_in) begin
                if (addr_is(wb_adr_in, EXT_CLK_CTRL_OFS)) begin
                    rdat_nxt[DIV_SEL_LSB +: 2] = div_sel_r;
                    rdat_nxt[SRC_SEL_BIT]      = src_sel_r;
                end else if (addr_is(wb_adr_in, CLK_CTRL_OFS)) begin
                    rdat_nxt[EXT_PATH_OFF_BIT] = ext_off_r;
                    rdat_nxt[XTAL_OFF_BIT]     = xtal_off_r;
                end else if (addr_is(wb_adr_in, PIN_MUX_OFS)) begin
                    rdat_nxt[MUX_CLKOUT_BIT] = mux_clkout_r;
                end else if (addr_is(wb_adr_in, STATUS_OFS)) begin
                    rdat_nxt[ST_CLKOUT_BIT]  = clk_div;
                    rdat_nxt[ST_EXTOSC_BIT]  = ext_osc_input_out;
                    rdat_nxt[ST_XTAL_EN_BIT] = xtal_osc_en_out;
                    rdat_nxt[ST_EXT_EN_BIT]  = ext_osc_path_en_out;
                    rdat_nxt[ST_DIV_LSB +: 2] = div_sel_r;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            div_sel_r    <= DIV_SEL_RST;
            src_sel_r    <= SRC_SEL_RST;
            ext_off_r    <= EXT_OFF_RST;
            xtal_off_r   <= XTAL_OFF_RST;
            mux_clkout_r <= MUX_CLKOUT_RST;
            ack_r        <= 1'b0;
            rdat_r       <= '0;
        end else if (ce_in) begin
            div_sel_r    <= div_sel_nxt;
            src_sel_r    <= src_sel_nxt;
            ext_off_r    <= ext_off_nxt;
            xtal_off_r   <= xtal_off_nxt;
            mux_clkout_r <= mux_clkout_nxt;
            ack_r        <= ack_nxt;
            rdat_r       <= rdat_nxt;
        end
    end

    assign wb_ack_out = ack_r;
    assign wb_dat_out = rdat_r;

    ////////////////////////////////////////////////////////////////////////
    // clock output divider and pin mux

    logic gpio_out_r;
    logic pin_oe_n_r;

    clkout_div u_div (
        .ref_clk_in  (ref_clk_in),
        .srst_in     (srst_in),
        .ce_in       (ce_in),
        .div_sel_in  (div_sel_r),
        .clk_div_out (clk_div)
    );

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            gpio_out_r <= 1'b0;
            pin_oe_n_r <= 1'b1;
        end else if (ce_in) begin
            gpio_out_r <= gpio_out_in;
            pin_oe_n_r <= mux_clkout_nxt ? 1'b0 : gpio_oe_n_in;
        end
    end

    // divided clock and gpio are both flop or gated-clock sources
    assign clkout_pin_out      = mux_clkout_r ? clk_div : gpio_out_r;
    assign clkout_pin_oe_n_out = pin_oe_n_r;

    ////////////////////////////////////////////////////////////////////////
    // oscillator input select and exclusion

    logic ext_in_r;
    logic ext_in_nxt;
    logic ext_en_r;
    logic xtal_en_r;

    always_comb begin
        ext_in_nxt = 1'b0;
        if (!ext_off_r) begin
            // tck path can be switched away during debug
            ext_in_nxt = src_sel_r ? pin_flt_r[1] : pin_flt_r[0];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ext_in_r  <= 1'b0;
            ext_en_r  <= !EXT_OFF_RST;
            xtal_en_r <= !XTAL_OFF_RST;
        end else if (ce_in) begin
            ext_in_r  <= ext_in_nxt;
            ext_en_r  <= !ext_off_r;
            xtal_en_r <= !xtal_off_r;
        end
    end

    assign ext_osc_input_out   = ext_in_r;
    assign ext_osc_path_en_out = ext_en_r;
    assign xtal_osc_en_out     = xtal_en_r;

endmodule

// File: core/clk_pin_pkg.sv
/*
 * Shared constants for the clock pin control block: register offsets,
 * field positions, reset values and divider encodings.
 * Assumes a 32-bit classic Wishbone register bus, byte addressed.
 */
package clk_pin_pkg;

    localparam int          WB_ADDR_W      = 8;
    localparam int          WB_DATA_W      = 32;

    // register byte offsets
    localparam logic [7:0]  EXT_CLK_CTRL_OFS = 8'h00;
    localparam logic [7:0]  CLK_CTRL_OFS     = 8'h04;
    localparam logic [7:0]  PIN_MUX_OFS      = 8'h08;
    localparam logic [7:0]  STATUS_OFS       = 8'h0c;

    // ext_clock_ctrl_reg fields
    localparam int          DIV_SEL_LSB    = 0;
    localparam int          SRC_SEL_BIT    = 6;
    // clock_control_reg fields
    localparam int          EXT_PATH_OFF_BIT = 13;
    localparam int          XTAL_OFF_BIT     = 14;
    // pin mux field
    localparam int          MUX_CLKOUT_BIT = 0;
    // status fields
    localparam int          ST_CLKOUT_BIT  = 0;
    localparam int          ST_EXTOSC_BIT  = 1;
    localparam int          ST_XTAL_EN_BIT = 2;
    localparam int          ST_EXT_EN_BIT  = 3;
    localparam int          ST_DIV_LSB     = 4;

    // divider select encodings
    localparam logic [1:0]  DIV_BY4        = 2'h0;
    localparam logic [1:0]  DIV_BY2        = 2'h1;
    localparam logic [1:0]  DIV_BY1        = 2'h2;
    localparam logic [1:0]  DIV_OFF        = 2'h3;

    // reset values
    localparam logic [1:0]  DIV_SEL_RST    = DIV_BY4;
    localparam logic        SRC_SEL_RST    = 1'b0;   // 0: tck shared pin
    localparam logic        EXT_OFF_RST    = 1'b0;
    localparam logic        XTAL_OFF_RST   = 1'b0;
    localparam logic        MUX_CLKOUT_RST = 1'b0;

    // quarter-rate divider toggles when its counter reaches this
    localparam logic [1:0]  DIV4_TOGGLE_AT = 2'h1;

endpackage

// File: core/clkout_div.sv
/*
 * Clock output divider: system clock undivided, by two, by four, or off.
 * Assumes div_sel_in is a registered control from the same clock domain.
 */
`timescale 1ns/1ns
module clkout_div
    import clk_pin_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       srst_in,
    input  wire logic       ce_in,
    input  wire logic [1:0] div_sel_in,
    output logic            clk_div_out
);

    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic       div_r;
    logic       div_nxt;
    logic [1:0] sel_r;
    logic       pass_r;

    always_comb begin
        cnt_nxt = cnt_r;
        div_nxt = div_r;
        if (div_sel_in != sel_r) begin
            // restart cleanly on any divider change
            cnt_nxt = 2'h0;
            div_nxt = 1'b0;
        end else begin
            case (div_sel_in)
                DIV_BY2: begin
                    div_nxt = ~div_r;
                end
                DIV_BY4: begin
                    cnt_nxt = cnt_r + 2'h1;
                    if (cnt_r == DIV4_TOGGLE_AT) begin
                        cnt_nxt = 2'h0;
                        div_nxt = ~div_r;
                    end
                end
                default: begin
                    cnt_nxt = 2'h0;
                    div_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            cnt_r <= 2'h0;
            div_r <= 1'b0;
            sel_r <= DIV_SEL_RST;
        end else if (ce_in) begin
            cnt_r <= cnt_nxt;
            div_r <= div_nxt;
            sel_r <= div_sel_in;
        end
    end

    // undivided gate opens on the falling edge so no high phase is cut
    always_ff @(negedge ref_clk_in) begin
        if (srst_in) begin
            pass_r <= 1'b0;
        end else begin
            pass_r <= ce_in && (div_sel_in == DIV_BY1);
        end
    end

    assign clk_div_out = (sel_r == DIV_BY1) ? (ref_clk_in & pass_r)
                                            : div_r;

endmodule

// File: test/clk_pin_props.sv
/*
 * Port checker for the clock pin control block.
 * Assumes one clock, sync active-high reset, bound to clk_pin_ctrl.
 */
`timescale 1ns/1ns
module clk_pin_props
    import clk_pin_pkg::*;
(
    input wire logic                 ref_clk_in,
    input wire logic                 srst_in,
    input wire logic                 ce_in,
    input wire logic                 wb_cyc_in,
    input wire logic                 wb_stb_in,
    input wire logic                 wb_we_in,
    input wire logic [WB_ADDR_W-1:0] wb_adr_in,
    input wire logic [3:0]           wb_sel_in,
    input wire logic [WB_DATA_W-1:0] wb_dat_in,
    input wire logic [WB_DATA_W-1:0] wb_dat_out,
    input wire logic                 wb_ack_out,
    input wire logic                 gpio_out_in,
    input wire logic                 clkout_pin_out,
    input wire logic                 clkout_pin_oe_n_out,
    input wire logic                 ext_osc_input_out,
    input wire logic                 ext_osc_path_en_out,
    input wire logic                 xtal_osc_en_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (srst_in);
    sequence s_take;
        wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in;
    endsequence
    sequence s_ctrl_wr;
        s_take ##0 wb_we_in && wb_adr_in == CLK_CTRL_OFS && wb_sel_in[1];
    endsequence
    a_ack_next: assert property (s_take |=> wb_ack_out)
        else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_out && ce_in |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    a_xtal_bit: assert property (s_ctrl_wr ##1 ce_in |=>
        xtal_osc_en_out == !$past(wb_dat_in[XTAL_OFF_BIT], 2))
        else $error("crystal enable wrong");
    a_path_bit: assert property (s_ctrl_wr ##1 ce_in |=>
        ext_osc_path_en_out == !$past(wb_dat_in[EXT_PATH_OFF_BIT], 2))
        else $error("external path enable wrong");
    a_path_gate: assert property (
        !ext_osc_path_en_out [*3] |-> !ext_osc_input_out)
        else $error("input passes while path off");
    a_reset_vals: assert property (disable iff (1'b0)
        srst_in && ce_in |=> ext_osc_path_en_out && xtal_osc_en_out
        && clkout_pin_oe_n_out && !wb_ack_out)
        else $error("reset values wrong");
    a_gpio_pass: assert property (
        clkout_pin_oe_n_out && ce_in && $past(ce_in) && !$past(srst_in)
        |-> clkout_pin_out == $past(gpio_out_in))
        else $error("pin not carrying other function");
    a_unmap_zero: assert property (s_take ##0 !wb_we_in
        && wb_adr_in > STATUS_OFS |=> wb_dat_out == '0)
        else $error("unmapped read not zero");
    a_ce_freeze: assert property (!ce_in |=> $stable(wb_ack_out)
        && $stable(xtal_osc_en_out))
        else $error("state moved with clock enable low");
endmodule
bind clk_pin_ctrl clk_pin_props u_props (
    .ref_clk_in          (ref_clk_in),
    .srst_in             (srst_in),
    .ce_in               (ce_in),
    .wb_cyc_in           (wb_cyc_in),
    .wb_stb_in           (wb_stb_in),
    .wb_we_in            (wb_we_in),
    .wb_adr_in           (wb_adr_in),
    .wb_sel_in           (wb_sel_in),
    .wb_dat_in           (wb_dat_in),
    .wb_dat_out          (wb_dat_out),
    .wb_ack_out          (wb_ack_out),
    .gpio_out_in         (gpio_out_in),
    .clkout_pin_out      (clkout_pin_out),
    .clkout_pin_oe_n_out (clkout_pin_oe_n_out),
    .ext_osc_input_out   (ext_osc_input_out),
    .ext_osc_path_en_out (ext_osc_path_en_out),
    .xtal_osc_en_out     (xtal_osc_en_out)
);

// File: test/ext_osc_model.sv
/*
 * Board model of the two oscillator input pins.
 * Assumes the bench sets levels and the tck pin drive.
 */
`timescale 1ns/1ns
module ext_osc_model (
    input  wire logic tck_drive_in,
    input  wire logic tck_level_in,
    input  wire logic alt_level_in,
    output logic      tck_shared_pin_out,
    output logic      alt_osc_in_pin_out
);
    // released tck pin goes to its pull-up
    assign tck_shared_pin_out = tck_drive_in ? tck_level_in : 1'b1;
    assign alt_osc_in_pin_out = alt_level_in;
endmodule

// File: test/tb_top.sv
/*
 * Self-checking bench for clk_pin_ctrl.
 * Assumes the checker bind and the oscillator pin model.
 */
`timescale 1ns/1ns
module tb_top;
    import clk_pin_pkg::*;
    logic                 ref_clk_in = 1'b0;
    logic                 srst_in = 1'b1;
    logic                 ce_in = 1'b1;
    logic                 wb_cyc_in = 1'b0;
    logic                 wb_stb_in = 1'b0;
    logic                 wb_we_in = 1'b0;
    logic [WB_ADDR_W-1:0] wb_adr_in = '0;
    logic [3:0]           wb_sel_in = 4'hf;
    logic [WB_DATA_W-1:0] wb_dat_in = '0;
    logic [WB_DATA_W-1:0] wb_dat_out;
    logic [WB_DATA_W-1:0] rd;
    logic                 wb_ack_out;
    logic                 gpio_out_in = 1'b0;
    logic                 gpio_oe_n_in = 1'b1;
    logic                 clkout_pin_out;
    logic                 clkout_pin_oe_n_out;
    logic                 tck_shared_pin_in;
    logic                 alt_osc_in_pin_in;
    logic                 ext_osc_input_out;
    logic                 ext_osc_path_en_out;
    logic                 xtal_osc_en_out;
    logic                 tck_drive = 1'b1;
    logic                 tck_level = 1'b0;
    logic                 alt_level = 1'b0;
    int                   num_errors = 0;
    int                   check_count = 0;
    int                   cycles = 0;
    int                   edges = 0;
    int                   exp_edges[4] = '{10, 20, 40, 0};

    clk_pin_ctrl dut (
        .ref_clk_in          (ref_clk_in),
        .srst_in             (srst_in),
        .ce_in               (ce_in),
        .wb_cyc_in           (wb_cyc_in),
        .wb_stb_in           (wb_stb_in),
        .wb_we_in            (wb_we_in),
        .wb_adr_in           (wb_adr_in),
        .wb_sel_in           (wb_sel_in),
        .wb_dat_in           (wb_dat_in),
        .wb_dat_out          (wb_dat_out),
        .wb_ack_out          (wb_ack_out),
        .gpio_out_in         (gpio_out_in),
        .gpio_oe_n_in        (gpio_oe_n_in),
        .clkout_pin_out      (clkout_pin_out),
        .clkout_pin_oe_n_out (clkout_pin_oe_n_out),
        .tck_shared_pin_in   (tck_shared_pin_in),
        .alt_osc_in_pin_in   (alt_osc_in_pin_in),
        .ext_osc_input_out   (ext_osc_input_out),
        .ext_osc_path_en_out (ext_osc_path_en_out),
        .xtal_osc_en_out     (xtal_osc_en_out)
    );
    ext_osc_model osc (
        .tck_drive_in       (tck_drive),
        .tck_level_in       (tck_level),
        .alt_level_in       (alt_level),
        .tck_shared_pin_out (tck_shared_pin_in),
        .alt_osc_in_pin_out (alt_osc_in_pin_in)
    );

    always #5 ref_clk_in = ~ref_clk_in;
    always @(posedge clkout_pin_out) edges++;
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat);
        @(posedge ref_clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in  <= we;
        wb_adr_in <= adr;
        wb_dat_in <= dat;
        do @(posedge ref_clk_in); while (wb_ack_out !== 1'b1);
        rd = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask
    // rising edges of the pin over 40 cycles, one edge of slack
    task automatic measure(input int exp);
        edges = 0;
        repeat (40) @(posedge ref_clk_in);
        check(exp, (edges >= exp - 1 && edges <= exp + 1) ? exp : edges);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        wb(1'b0, STATUS_OFS, 32'h0);
        check(32'h3, rd[5:2]);
        check(32'h1, clkout_pin_oe_n_out);
        wb(1'b1, PIN_MUX_OFS, 32'h1);
        measure(10);
        $display("test reset done");
    endtask
    task automatic t_div;
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, EXT_CLK_CTRL_OFS, i);
            repeat (4) @(posedge ref_clk_in);
            measure(exp_edges[i]);
            check(32'h0, clkout_pin_oe_n_out);
        end
        check(32'h0, clkout_pin_out);
        $display("test divider done");
    endtask
    task automatic t_mux;
        wb(1'b1, EXT_CLK_CTRL_OFS, 32'h1);
        wb(1'b1, PIN_MUX_OFS, 32'h0);
        gpio_out_in  <= 1'b1;
        gpio_oe_n_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        check(32'h1, clkout_pin_out);
        check(32'h0, clkout_pin_oe_n_out);
        measure(0);
        gpio_out_in <= 1'b0;
        $display("test mux done");
    endtask
    task automatic t_src;
        tck_level <= 1'b1;
        wb(1'b1, EXT_CLK_CTRL_OFS, 32'h1);
        repeat (8) @(posedge ref_clk_in);
        check(32'h1, ext_osc_input_out);
        wb(1'b1, EXT_CLK_CTRL_OFS, 32'h41);
        repeat (8) @(posedge ref_clk_in);
        check(32'h0, ext_osc_input_out);
        tck_drive <= 1'b0;
        alt_level <= 1'b1;
        repeat (8) @(posedge ref_clk_in);
        check(32'h1, ext_osc_input_out);
        $display("test source done");
    endtask
    task automatic t_paths;
        wb(1'b1, CLK_CTRL_OFS, 32'h2000);
        repeat (6) @(posedge ref_clk_in);
        check(32'h0, ext_osc_path_en_out);
        check(32'h0, ext_osc_input_out);
        wb(1'b1, CLK_CTRL_OFS, 32'h4000);
        ce_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        ce_in <= 1'b1;
        check(32'h0, xtal_osc_en_out);
        wb(1'b0, STATUS_OFS, 32'h0);
        check(32'h6, rd[5:2]);
        // lane 0 masked: divider and source bits must not move
        wb_sel_in <= 4'he;
        wb(1'b1, EXT_CLK_CTRL_OFS, 32'h0);
        wb_sel_in <= 4'hf;
        wb(1'b0, EXT_CLK_CTRL_OFS, 32'h0);
        check(32'h41, rd);
        wb(1'b0, 8'h10, 32'h0);
        check(32'h0, rd);
        $display("test paths done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        t_reset();
        t_div();
        t_mux();
        t_src();
        t_paths();
        complete_run();
    end
endmodule
